// [sarseq_top.sv]
`default_nettype none
module sarseq_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // supply monitor: low while core supply is under threshold
    input wire logic supply_ok,
    // host control
    input wire logic conversion_start,
    input wire logic power_down_pin,
    input wire logic [sarseq_pkg::NUM_CH-1:0] ch_enable,
    // status
    output logic busy,
    output logic track_hold,
    output logic nap_active,
    output logic powered_down,
    output logic global_reset,
    output logic conv_done
);
    sarseq_pkg::sarseq_state_t state_r, state_nxt;
    logic [sarseq_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic start_d_r, pd_d_r;
    logic pd_armed_r, pd_armed_nxt;
    logic pdn_r, pdn_nxt;
    logic done_r, done_nxt;
    logic start_rise, pd_rise, por_n;

    function automatic logic [sarseq_pkg::CNT_W-1:0] conv_cycles(
        input logic [sarseq_pkg::NUM_CH-1:0] en);
        // counted at full counter width: eight channels times five overflows a nibble
        logic [sarseq_pkg::CNT_W-1:0] n;
        n = sarseq_pkg::CNT_ZERO;
        for (int i = 0; i < sarseq_pkg::NUM_CH; i++) begin
            n = n + sarseq_pkg::CNT_W'(en[i]);
        end
        if (n == sarseq_pkg::CNT_ZERO) begin
            n = sarseq_pkg::CNT_ONE;
        end
        return sarseq_pkg::CNT_W'(n * sarseq_pkg::CNT_W'(sarseq_pkg::CONV_PER_CH_CYC));
    endfunction

    // supply dip acts like the external reset
    assign por_n = nrst & supply_ok;
    assign start_rise = conversion_start & ~start_d_r;
    assign pd_rise = power_down_pin & ~pd_d_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pd_armed_nxt = pd_armed_r;
        pdn_nxt = pdn_r;
        done_nxt = 1'b0;
        if (pd_rise) begin
            pd_armed_nxt = 1'b1;
        end
        if (!power_down_pin && state_r != sarseq_pkg::SARSEQ_CONV) begin
            pdn_nxt = 1'b0;
        end
        unique case (state_r)
            sarseq_pkg::SARSEQ_IDLE: begin
                // starts during power-down are dropped
                if (start_rise && !pdn_r && !power_down_pin) begin
                    state_nxt = sarseq_pkg::SARSEQ_CONV;
                    cnt_nxt = conv_cycles(ch_enable);
                    pd_armed_nxt = 1'b0;
                end else if (power_down_pin) begin
                    pdn_nxt = 1'b1;
                end
            end
            sarseq_pkg::SARSEQ_CONV: begin
                // start edges here are ignored, only the count, a global reset or por_n low ends it
                if (cnt_r == sarseq_pkg::CNT_ONE) begin
                    done_nxt = 1'b1;
                    if (power_down_pin) begin
                        pdn_nxt = 1'b1;
                        state_nxt = sarseq_pkg::SARSEQ_IDLE;
                    end else if (conversion_start) begin
                        state_nxt = sarseq_pkg::SARSEQ_NAP;
                    end else begin
                        state_nxt = sarseq_pkg::SARSEQ_IDLE;
                    end
                end else begin
                    cnt_nxt = cnt_r - sarseq_pkg::CNT_ONE;
                end
            end
            sarseq_pkg::SARSEQ_NAP: begin
                // leaves on start low; acquisition is the low time
                if (!conversion_start) begin
                    state_nxt = sarseq_pkg::SARSEQ_IDLE;
                end
            end
            sarseq_pkg::SARSEQ_RST: begin
                if (cnt_r == sarseq_pkg::CNT_ONE) begin
                    state_nxt = sarseq_pkg::SARSEQ_IDLE;
                    cnt_nxt = sarseq_pkg::CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_r - sarseq_pkg::CNT_ONE;
                end
            end
        endcase
        // second power-down rise with no conversion between wins over all, except during the reset pulse itself
        if (pd_rise && pd_armed_r && state_r != sarseq_pkg::SARSEQ_RST) begin
            state_nxt = sarseq_pkg::SARSEQ_RST;
            cnt_nxt = sarseq_pkg::CNT_W'(sarseq_pkg::RESET_PULSE_CYC);
            pd_armed_nxt = 1'b0;
            pdn_nxt = 1'b1;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge por_n) begin
        if (!por_n) begin
            state_r <= sarseq_pkg::SARSEQ_IDLE;
            cnt_r <= sarseq_pkg::CNT_ZERO;
            start_d_r <= 1'b0;
            pd_d_r <= 1'b0;
            pd_armed_r <= 1'b0;
            pdn_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            start_d_r <= conversion_start;
            pd_d_r <= power_down_pin;
            pd_armed_r <= pd_armed_nxt;
            pdn_r <= pdn_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (state_r == sarseq_pkg::SARSEQ_CONV);
    // hold for all channels together during conversion
    assign track_hold = (state_r == sarseq_pkg::SARSEQ_CONV);
    assign nap_active = (state_r == sarseq_pkg::SARSEQ_NAP);
    assign powered_down = pdn_r;
    assign global_reset = (state_r == sarseq_pkg::SARSEQ_RST);
    assign conv_done = done_r;

    AST_START_BUSY: assert property (@(posedge clk_sys) disable iff (!por_n)
        (state_r == sarseq_pkg::SARSEQ_IDLE && start_rise && !power_down_pin && !pdn_r
         && !(pd_rise && pd_armed_r)) |=> busy)
        else $error("start edge did not raise busy");
    AST_BUSY_MIN: assert property (@(posedge clk_sys) disable iff (!por_n)
        $rose(busy) && !power_down_pin |-> (busy || global_reset) [*5])
        else $error("conversion ended early");
    AST_BUSY_MAX: assert property (@(posedge clk_sys) disable iff (!por_n)
        $rose(busy) |-> ##[1:44] !busy)
        else $error("conversion too long");
    AST_DONE_FALL: assert property (@(posedge clk_sys) disable iff (!por_n)
        conv_done |-> $past(busy) && !busy)
        else $error("done without busy falling");
    AST_NAP_ENTRY: assert property (@(posedge clk_sys) disable iff (!por_n)
        $rose(nap_active) |-> $past(busy) && $past(conversion_start))
        else $error("nap entered wrongly");
    AST_NAP_EXIT: assert property (@(posedge clk_sys) disable iff (!por_n)
        nap_active && !conversion_start && !global_reset |=> !nap_active)
        else $error("nap not left on start low");
    AST_PD_IGNORE: assert property (@(posedge clk_sys) disable iff (!por_n)
        !busy && powered_down |=> !busy)
        else $error("conversion during power-down");
    AST_RST_HALT: assert property (@(posedge clk_sys) disable iff (!por_n)
        pd_rise && pd_armed_r && !global_reset |=> global_reset && !busy)
        else $error("global reset did not halt");
    AST_NO_RESTART: assert property (@(posedge clk_sys) disable iff (!por_n)
        busy && start_rise && !conv_done |=> !$rose(busy))
        else $error("start accepted while busy");

    // conversion bookkeeping
    AST_BUSY_FROM_START: assert property (@(posedge clk_sys) disable iff (!por_n)
        $rose(busy) |-> $past(start_rise))
        else $error("busy rose without a start edge");
    AST_DONE_AFTER_BUSY: assert property (@(posedge clk_sys) disable iff (!por_n)
        $fell(busy) && !global_reset |-> conv_done)
        else $error("busy fell without done pulse");
    AST_NAP_HOLD: assert property (@(posedge clk_sys) disable iff (!por_n)
        nap_active && conversion_start && !(pd_rise && pd_armed_r) |=> nap_active)
        else $error("nap left while start high");
    AST_NO_START_IN_NAP: assert property (@(posedge clk_sys) disable iff (!por_n)
        nap_active |=> !busy)
        else $error("conversion started straight from nap");

    // power-down handling
    AST_PD_AFTER_CONV: assert property (@(posedge clk_sys) disable iff (!por_n)
        $fell(busy) && power_down_pin && !global_reset |-> powered_down)
        else $error("power-down not taken after conversion");
    AST_PD_ENTER: assert property (@(posedge clk_sys) disable iff (!por_n)
        !busy && !global_reset && !nap_active && power_down_pin |=> powered_down)
        else $error("power-down not entered");
    AST_PD_LEAVE: assert property (@(posedge clk_sys) disable iff (!por_n)
        powered_down && !power_down_pin && !busy |=> !powered_down)
        else $error("power-down not left");

    // global reset pulse
    AST_RST_LEN: assert property (@(posedge clk_sys) disable iff (!por_n)
        $rose(global_reset) |-> global_reset [*4] ##1 !global_reset)
        else $error("reset pulse length wrong");
    AST_RST_NO_BUSY: assert property (@(posedge clk_sys) disable iff (!por_n)
        global_reset |-> !busy)
        else $error("busy during reset pulse");
endmodule // sarseq_top
`default_nettype wire

// [sarseq_pkg.sv]
`default_nettype none
package sarseq_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned CH_IDX_W = 3;
    localparam int unsigned CH_CNT_W = 4;
    // longest conversion per enabled channel, rounded down to whole cycles
    localparam int unsigned CONV_PER_CH_NS = 550;
    localparam int unsigned CONV_PER_CH_CYC =
        (CONV_PER_CH_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_PER_CH_NS / CLK_PERIOD_NS);
    localparam int unsigned CNT_W = 6;
    // reset pulse after the second power-down rise
    localparam int unsigned RESET_PULSE_CYC = 4;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    typedef enum logic [1:0] {
        SARSEQ_IDLE = 2'b00,
        SARSEQ_CONV = 2'b01,
        SARSEQ_NAP  = 2'b10,
        SARSEQ_RST  = 2'b11
    } sarseq_state_t;
endpackage
`default_nettype wire

// [sarseq_host.sv]
`default_nettype none
module sarseq_host (
    // clock and bench control
    input wire logic clk_sys,
    input wire logic req,
    input wire logic rude,
    // device side
    input wire logic busy,
    output logic conversion_start
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_r = 1'b0;
    logic [3:0] low_cnt_r = 4'h0;
    // edges launched on falling clock, no other lines toggle near them
    always @(negedge clk_sys) begin
        if (!cs_r && req && low_cnt_r >= 4'h8) cs_r <= 1'b1;
        else if (cs_r && !req && !busy) cs_r <= 1'b0;
        low_cnt_r <= cs_r ? 4'h0 : (low_cnt_r == 4'h8 ? low_cnt_r : low_cnt_r + 4'h1);
    end
    // rude mode lets the bench break start timing on purpose
    assign conversion_start = rude ? req : cs_r;
endmodule // sarseq_host
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] en; int n_ch;} sarseq_row_t;
    logic clk_sys, nrst, supply_ok, power_down_pin, req, rude, conversion_start;
    logic [7:0] ch_enable;
    logic busy, track_hold, nap_active, powered_down, global_reset, conv_done;
    int miscompares = 0, n_checks = 0, cyc = 0;
    sarseq_row_t rows[5] = '{'{8'h01, 1}, '{8'h03, 2}, '{8'hff, 8}, '{8'h00, 1}, '{8'h80, 1}};
    sarseq_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .supply_ok(supply_ok),
        .conversion_start(conversion_start), .power_down_pin(power_down_pin),
        .ch_enable(ch_enable), .busy(busy), .track_hold(track_hold), .nap_active(nap_active),
        .powered_down(powered_down), .global_reset(global_reset), .conv_done(conv_done));
    sarseq_host host_u (.clk_sys(clk_sys), .req(req), .rude(rude), .busy(busy),
        .conversion_start(conversion_start));
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // counts busy cycles from the current falling edge on
    task automatic run(output int len);
        len = 0;
        req = 1'b1;
        for (int i = 0; i < 30 && busy !== 1'b1; i++) @(negedge clk_sys);
        while (busy === 1'b1 && len < 100) begin
            chk({7'h0, track_hold}, 8'h01);
            @(negedge clk_sys);
            len++;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        int len;
        int n;
        {nrst, supply_ok, power_down_pin, req, rude, ch_enable} = '0;
        supply_ok = 1'b1;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        chk({2'h0, busy, track_hold, nap_active, powered_down, global_reset, conv_done}, 8'h00);
        repeat (2) @(negedge clk_sys);
        foreach (rows[k]) begin
            ch_enable = rows[k].en;
            run(len);
            chk(8'(len), 8'(rows[k].n_ch * sarseq_pkg::CONV_PER_CH_CYC));
            chk({6'h0, conv_done, nap_active}, 8'h03);
            req = 1'b0;
            repeat (10) @(negedge clk_sys);
            chk({7'h0, nap_active}, 8'h00);
        end
        // extra start edge in mid-conversion must not restart it
        rude = 1'b1;
        ch_enable = 8'h03;
        req = 1'b1;
        for (int i = 0; i < 4 && busy !== 1'b1; i++) @(negedge clk_sys);
        req = 1'b0;
        @(negedge clk_sys);
        run(len);
        chk(8'(len), 8'(2 * sarseq_pkg::CONV_PER_CH_CYC - 1));
        req = 1'b0;
        rude = 1'b0;
        repeat (10) @(negedge clk_sys);
        // two power-down rises with no conversion between
        power_down_pin = 1'b1;
        repeat (3) @(negedge clk_sys);
        power_down_pin = 1'b0;
        repeat (3) @(negedge clk_sys);
        power_down_pin = 1'b1;
        n = 0;
        repeat (10) begin
            @(negedge clk_sys);
            n += int'(global_reset === 1'b1);
        end
        chk(8'(n), 8'(sarseq_pkg::RESET_PULSE_CYC));
        chk({7'h0, powered_down}, 8'h01);
        req = 1'b1;
        repeat (12) @(negedge clk_sys);
        chk({7'h0, busy}, 8'h00);
        req = 1'b0;
        power_down_pin = 1'b0;
        repeat (10) @(negedge clk_sys);
        chk({7'h0, powered_down}, 8'h00);
        // supply dip halts a running conversion
        req = 1'b1;
        for (int i = 0; i < 30 && busy !== 1'b1; i++) @(negedge clk_sys);
        supply_ok = 1'b0;
        @(negedge clk_sys);
        chk({7'h0, busy}, 8'h00);
        req = 1'b0;
        repeat (2) @(negedge clk_sys);
        supply_ok = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({7'h0, busy}, 8'h00);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
